// ===== ldf_laser_drive.sv
// Emitter drive control with forced-off default, pulsed and continuous drive and single-fault supervision.
// Assumes a serial front end presents decoded register reads and writes on mclk.
`timescale 1ns/1ps
`default_nettype none
module ldf_laser_drive #(
  parameter int SELFTEST_CYCLES = ldf_pkg::LDF_SELFTEST_PERIOD_CYCLES,
  parameter int PULSE_PERIOD    = ldf_pkg::LDF_PULSE_PERIOD_CYCLES,
  parameter int PULSE_ON        = ldf_pkg::LDF_PULSE_ON_CYCLES
) (
  input  wire logic       mclk,                      // System clock, 25 MHz.
  input  wire logic       nrst,                      // Asynchronous reset, active low.
  input  wire logic [7:0] reg_addr,                  // Register address.
  input  wire logic       reg_wr,                    // Write strobe, one cycle.
  input  wire logic [7:0] reg_wdata,                 // Write data.
  input  wire logic       reg_rd,                    // Read strobe, one cycle.
  output logic [7:0]      reg_rdata,                 // Read data, valid the cycle after reg_rd.
  input  wire logic       cathode_leak_in,           // Comparator: cathode node pulled low, async.
  output logic            emitter_drive_on,          // Current source enable at the current node.
  output logic            emitter_switch_low_active, // Active-low enable of the external switch.
  output logic            cathode_test_sink,         // Internal path to ground for self-test.
  output ldf_pkg::ldf_status_t fault_status          // Fault and self-test state.
);
  import ldf_pkg::*;

  localparam logic [LDF_CNT_W-1:0] PULSE_LAST = LDF_CNT_W'(PULSE_PERIOD - 1);
  localparam logic [LDF_CNT_W-1:0] PULSE_HIGH = LDF_CNT_W'(PULSE_ON);

  ldf_ctrl_t            ctrl_reg;
  ldf_status_t          status_reg;
  logic [7:0]           rdata_reg;
  logic                 leak_meta_reg;
  logic                 leak_sync_reg;
  logic [LDF_CNT_W-1:0] pulse_cnt_reg;
  logic                 drive_reg;
  logic                 switch_open_reg;
  logic                 drive_next;
  logic                 switch_open_next;
  logic                 test_active;
  logic                 test_sink;
  logic                 test_fail;
  logic                 leak_event;
  logic                 fault_now;
  logic                 pulse_phase;

  // Two-stage synchroniser for the analog comparator.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      leak_meta_reg <= 1'b0;
      leak_sync_reg <= 1'b0;
    end else begin
      leak_meta_reg <= cathode_leak_in;
      leak_sync_reg <= leak_meta_reg;
    end
  end

  ldf_selftest #(
    .INTERVAL_CYCLES (SELFTEST_CYCLES),
    .SETTLE_CYCLES   (LDF_SETTLE_CYCLES)
  ) u_selftest (
    .mclk        (mclk),
    .nrst        (nrst),
    .leak_seen   (leak_sync_reg),
    .test_active (test_active),
    .test_sink   (test_sink),
    .test_fail   (test_fail)
  );

  // A low cathode only counts as a leak outside the self-test, where it is expected.
  assign leak_event = leak_sync_reg && !test_active;
  assign fault_now  = status_reg.fault_latched || leak_event || test_fail;

  // Control register; forced-off is set from reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= ldf_ctrl_t'(LDF_EMITTER_CONTROL_RESET);
    end else if (reg_wr && reg_addr == LDF_EMITTER_CONTROL_ADDR) begin
      ctrl_reg <= ldf_ctrl_t'(reg_wdata);
    end
  end

  // Fault flags are sticky until reset; nothing but reset clears them.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= '0;
    end else begin
      status_reg.selftest_busy <= test_active;
      if (leak_event) begin
        status_reg.leak_fault <= 1'b1;
      end
      if (test_fail) begin
        status_reg.selftest_fail <= 1'b1;
      end
      if (leak_event || test_fail) begin
        status_reg.fault_latched <= 1'b1;
      end
    end
  end

  // Free-running pulse timer for normal drive.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pulse_cnt_reg <= '0;
    end else if (pulse_cnt_reg == PULSE_LAST) begin
      pulse_cnt_reg <= '0;
    end else begin
      pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
    end
  end

  assign pulse_phase = (pulse_cnt_reg < PULSE_HIGH);

  always_comb begin
    drive_next = 1'b0;
    if (!fault_now && !ctrl_reg.forced_off && !test_active) begin
      if (ctrl_reg.drive_mode == LDF_MODE_CONTINUOUS) begin
        drive_next = 1'b1;
      end else begin
        drive_next = pulse_phase;
      end
    end
    // The switch opens for any fault and for the duration of each self-test.
    switch_open_next = fault_now || test_active;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drive_reg       <= 1'b0;
      switch_open_reg <= 1'b0;
    end else begin
      drive_reg       <= drive_next;
      switch_open_reg <= switch_open_next;
    end
  end

  // Read port; unmapped addresses read as zero.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        LDF_EMITTER_CONTROL_ADDR: rdata_reg <= ctrl_reg;
        LDF_FAULT_STATUS_ADDR:    rdata_reg <= {4'h0, status_reg};
        default:                  rdata_reg <= 8'h00;
      endcase
    end
  end

  assign reg_rdata                 = rdata_reg;
  assign emitter_drive_on          = drive_reg;
  assign emitter_switch_low_active = switch_open_reg;
  assign cathode_test_sink         = test_sink;
  assign fault_status              = status_reg;

endmodule : ldf_laser_drive
`default_nettype wire

// ===== ldf_pkg.sv
// Constants, register map and shared types of the emitter drive and fault supervision block.
// Assumes a single 25 MHz clock and a register port that the serial front end drives.
package ldf_pkg;

  localparam logic [7:0] LDF_EMITTER_CONTROL_ADDR  = 8'h20;
  localparam logic [7:0] LDF_FAULT_STATUS_ADDR     = 8'h21;
  localparam logic [7:0] LDF_EMITTER_CONTROL_RESET = 8'h01;
  localparam logic [2:0] LDF_MODE_CONTINUOUS       = 3'h2;

  localparam int LDF_CLK_PERIOD_NS      = 40;
  localparam int LDF_PULSE_PERIOD_NS    = 2000;
  localparam int LDF_PULSE_ON_NS        = 400;
  localparam int LDF_SELFTEST_PERIOD_NS = 1000000;
  localparam int LDF_SETTLE_NS          = 2000;

  // Longest times round down, least times round up.
  localparam int LDF_PULSE_PERIOD_CYCLES    = LDF_PULSE_PERIOD_NS / LDF_CLK_PERIOD_NS;
  localparam int LDF_PULSE_ON_CYCLES        = (LDF_PULSE_ON_NS + LDF_CLK_PERIOD_NS - 1) / LDF_CLK_PERIOD_NS;
  localparam int LDF_SELFTEST_PERIOD_CYCLES = LDF_SELFTEST_PERIOD_NS / LDF_CLK_PERIOD_NS;
  localparam int LDF_SETTLE_CYCLES          = (LDF_SETTLE_NS + LDF_CLK_PERIOD_NS - 1) / LDF_CLK_PERIOD_NS;

  localparam int LDF_CNT_W = 24;

  typedef struct packed {
    logic [3:0] spare;
    logic [2:0] drive_mode;
    logic       forced_off;
  } ldf_ctrl_t;

  typedef struct packed {
    logic selftest_busy;
    logic selftest_fail;
    logic leak_fault;
    logic fault_latched;
  } ldf_status_t;

  typedef enum logic [2:0] {
    LDF_ST_WAIT    = 3'b001,
    LDF_ST_SINK    = 3'b010,
    LDF_ST_RECOVER = 3'b100
  } ldf_test_state_t;

endpackage : ldf_pkg

// ===== ldf_selftest.sv
// Periodic self-test sequencer of the cathode fault detector.
// Assumes leak_seen is already synchronised to mclk.
`timescale 1ns/1ps
`default_nettype none
module ldf_selftest #(
  parameter int INTERVAL_CYCLES = ldf_pkg::LDF_SELFTEST_PERIOD_CYCLES,
  parameter int SETTLE_CYCLES   = ldf_pkg::LDF_SETTLE_CYCLES
) (
  input  wire logic mclk,        // System clock.
  input  wire logic nrst,        // Asynchronous reset, active low.
  input  wire logic leak_seen,   // Synchronised cathode-low indication.
  output logic      test_active, // High while a self-test holds the emitter off.
  output logic      test_sink,   // Enables the internal path to ground.
  output logic      test_fail    // One-cycle pulse when the cathode did not fall.
);
  import ldf_pkg::*;

  localparam logic [LDF_CNT_W-1:0] INTERVAL_LAST = LDF_CNT_W'(INTERVAL_CYCLES - 1);
  localparam logic [LDF_CNT_W-1:0] SETTLE_LAST   = LDF_CNT_W'(SETTLE_CYCLES - 1);

  ldf_test_state_t        state_reg;
  logic [LDF_CNT_W-1:0]   cnt_reg;
  logic                   fail_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= LDF_ST_WAIT;
      cnt_reg   <= '0;
      fail_reg  <= 1'b0;
    end else begin
      fail_reg <= 1'b0;
      unique case (state_reg)
        LDF_ST_WAIT: begin
          if (cnt_reg == INTERVAL_LAST) begin
            state_reg <= LDF_ST_SINK;
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        LDF_ST_SINK: begin
          if (cnt_reg == SETTLE_LAST) begin
            fail_reg  <= !leak_seen;
            state_reg <= LDF_ST_RECOVER;
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        LDF_ST_RECOVER: begin
          // The detector needs time to clear before leaks count as faults again.
          if (cnt_reg == SETTLE_LAST) begin
            state_reg <= LDF_ST_WAIT;
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= LDF_ST_WAIT;
          cnt_reg   <= '0;
        end
      endcase
    end
  end

  assign test_active = (state_reg != LDF_ST_WAIT);
  assign test_sink   = (state_reg == LDF_ST_SINK);
  assign test_fail   = fail_reg;

endmodule : ldf_selftest
`default_nettype wire

// ===== ldf_props.sv
// Assertions on the ports of the emitter drive block.
// Bound into ldf_laser_drive; mirrors the control register from the write port.
`timescale 1ns/1ps
`default_nettype none
module ldf_props (
  input wire logic                 mclk,                      // Clock.
  input wire logic                 nrst,                      // Reset, active low.
  input wire logic [7:0]           reg_addr,                  // Address.
  input wire logic                 reg_wr,                    // Write strobe.
  input wire logic [7:0]           reg_wdata,                 // Write data.
  input wire logic                 reg_rd,                    // Read strobe.
  input wire logic [7:0]           reg_rdata,                 // Read data.
  input wire logic                 cathode_leak_in,           // Comparator.
  input wire logic                 emitter_drive_on,          // Drive enable.
  input wire logic                 emitter_switch_low_active, // Switch enable.
  input wire logic                 cathode_test_sink,         // Ground path.
  input wire ldf_pkg::ldf_status_t fault_status               // Status.
);
  import ldf_pkg::*;
  ldf_ctrl_t c_reg;
  logic      continuous_drive;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) c_reg <= LDF_EMITTER_CONTROL_RESET;
    else if (reg_wr && reg_addr == LDF_EMITTER_CONTROL_ADDR) c_reg <= reg_wdata;
  end
  assign continuous_drive = !c_reg.forced_off && c_reg.drive_mode == LDF_MODE_CONTINUOUS;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  fault_off_a: assert property (fault_status.fault_latched |-> !emitter_drive_on && emitter_switch_low_active)
    else $error("drive not off under fault");
  fault_hold_a: assert property (fault_status.fault_latched |=> fault_status.fault_latched)
    else $error("fault released");
  // The self-test sink pulls the node low on purpose, so its own edge is not a leak.
  leak_trip_a: assert property ($rose(cathode_leak_in) && !emitter_switch_low_active && !cathode_test_sink
      |-> ##[1:5] fault_status.leak_fault)
    else $error("leak not caught");
  sink_off_a: assert property (cathode_test_sink && $past(cathode_test_sink) |-> emitter_switch_low_active && !emitter_drive_on)
    else $error("sink with emitter on");
  test_fail_a: assert property (fault_status.selftest_fail |-> ##[0:2] fault_status.fault_latched)
    else $error("failed test not latched");
  forced_dark_a: assert property (c_reg.forced_off && $past(c_reg.forced_off) && $past(c_reg.forced_off, 2) |-> !emitter_drive_on)
    else $error("lit while forced off");
  steady_drive_a: assert property (continuous_drive && $past(continuous_drive) && $past(continuous_drive, 2)
      && !emitter_switch_low_active && !$past(emitter_switch_low_active) |-> emitter_drive_on)
    else $error("steady drive missing");
  pulse_len_a: assert property ($rose(emitter_drive_on) && !continuous_drive ##10 !continuous_drive
      |-> !emitter_drive_on)
    else $error("pulse too long");
  ctrl_read_a: assert property (reg_rd && !reg_wr && reg_addr == LDF_EMITTER_CONTROL_ADDR |=> reg_rdata == $past(c_reg))
    else $error("control readback wrong");
  cover property (cathode_test_sink);
  cover property (fault_status.leak_fault);
  cover property (continuous_drive && emitter_drive_on);
  cover property (fault_status.selftest_fail);
endmodule : ldf_props
bind ldf_laser_drive ldf_props u_props (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cathode_leak_in(cathode_leak_in),
  .emitter_drive_on(emitter_drive_on), .emitter_switch_low_active(emitter_switch_low_active),
  .cathode_test_sink(cathode_test_sink), .fault_status(fault_status));
`default_nettype wire

// ===== ldf_emitter_model.sv
// Behavioural model of the cathode node behind the external switch.
// Faults on the node are injected by the bench.
`timescale 1ns/1ps
`default_nettype none
module ldf_emitter_model (
  input  wire logic test_sink,  // Internal ground path.
  input  wire logic leak_gnd,   // Injected leak to ground.
  input  wire logic rail_short, // Injected short to a rail.
  output logic      leak_out    // Cathode pulled low.
);
  // A rail short holds the node high, so neither the sink nor a leak can pull it down.
  assign leak_out = !rail_short && (test_sink || leak_gnd);
endmodule : ldf_emitter_model
`default_nettype wire

// ===== testbench.sv
// Self-checking bench of the emitter drive block.
// Drives the register port at the falling edge; the model closes the cathode loop.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ldf_pkg::*;
  logic        mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, leak_gnd = 1'b0, rail_short = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rdata, n;
  logic        drive_on, sw_n, sink, leak_in;
  ldf_status_t st;
  int          error_cnt = 0, n_tests = 0, cyc = 0;
  // Each row: control value, then expected drive cycles in a 50 cycle window.
  logic [15:0] rows [11] = '{16'h000a, 16'h020a, 16'h0432, 16'h060a, 16'h080a, 16'h0a0a,
                             16'h0c0a, 16'h0e0a, 16'h0500, 16'hf432, 16'h0100};
  ldf_laser_drive #(.SELFTEST_CYCLES(2000)) u_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rdata), .cathode_leak_in(leak_in),
    .emitter_drive_on(drive_on), .emitter_switch_low_active(sw_n), .cathode_test_sink(sink), .fault_status(st));
  ldf_emitter_model u_model (.test_sink(sink), .leak_gnd(leak_gnd), .rail_short(rail_short), .leak_out(leak_in));
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
  endtask : rd
  task automatic count;
    n = 8'h00;
    repeat (50) @(negedge mclk) n = n + 8'(drive_on);
  endtask : count
  task automatic wait_sink(input logic lvl);
    int i;
    i = 0;
    while (sink !== lvl && i < 3000) begin
      @(negedge mclk);
      i++;
    end
    chk(8'(sink), 8'(lvl));
  endtask : wait_sink
  task automatic do_reset;
    nrst = 1'b0;
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
  endtask : do_reset
  initial begin
    do_reset();
    chk(8'(sw_n), 8'h00);
    chk(8'(st), 8'h00);
    rd(LDF_EMITTER_CONTROL_ADDR);
    chk(rdata, 8'h01);
    count();
    chk(n, 8'h00);
    foreach (rows[i]) begin
      wr(LDF_EMITTER_CONTROL_ADDR, rows[i][15:8]);
      rd(LDF_EMITTER_CONTROL_ADDR);
      chk(rdata, rows[i][15:8]);
      count();
      chk(n, rows[i][7:0]);
    end
    wr(LDF_EMITTER_CONTROL_ADDR, 8'h00);
    wr(LDF_EMITTER_CONTROL_ADDR, 8'h04);
    wr(LDF_FAULT_STATUS_ADDR, 8'h00);
    rd(LDF_EMITTER_CONTROL_ADDR);
    chk(rdata, 8'h04);
    rd(8'h33);
    chk(rdata, 8'h00);
    wait_sink(1'b1);
    @(negedge mclk);
    chk(8'(sw_n), 8'h01);
    chk(8'(drive_on), 8'h00);
    chk(8'(st.selftest_busy), 8'h01);
    wait_sink(1'b0);
    repeat (60) @(negedge mclk);
    chk(8'(st), 8'h00);
    chk(8'(drive_on), 8'h01);
    leak_gnd = 1'b1;
    repeat (8) @(negedge mclk);
    leak_gnd = 1'b0;
    chk(8'(drive_on), 8'h00);
    chk(8'(sw_n), 8'h01);
    chk(8'(st[1:0]), 8'h03);
    rd(LDF_FAULT_STATUS_ADDR);
    chk(rdata, 8'h03);
    repeat (100) @(negedge mclk);
    chk(8'(sw_n), 8'h01);
    rail_short = 1'b1;
    do_reset();
    chk(8'(st), 8'h00);
    chk(8'(sw_n), 8'h00);
    wr(LDF_EMITTER_CONTROL_ADDR, 8'h00);
    wait_sink(1'b1);
    wait_sink(1'b0);
    repeat (3) @(negedge mclk);
    chk(8'(st.fault_latched), 8'h01);
    count();
    chk(n, 8'h00);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
